// ---- shared/acfs_pkg.sv ----
package acfs_pkg;
  localparam int unsigned CHANNELS        = 16;
  localparam int unsigned PAIR_OFFSET     = 8;
  localparam int unsigned TABLE_MAX       = 128;
  localparam int unsigned DELAY_MAX       = 65535;
  localparam int unsigned CLK_HZ          = 125000000;
  localparam int unsigned PERIOD_NS       = 8;
  localparam int unsigned TEMP_PERIOD_MS  = 1000;
  localparam int unsigned TEMP_CYCLES     = TEMP_PERIOD_MS * (CLK_HZ / 1000);
  localparam int unsigned START_DIV_DEF   = 250;
  localparam int unsigned SUBRANGES       = 3;
  localparam logic [15:0] TEMP_TAG        = 16'hFF00;
  localparam logic [23:0] RST_CODE        = 24'h000000;

  typedef enum logic [1:0] {
    ACFS_SRC_VOLT = 2'b00,
    ACFS_SRC_RES  = 2'b01,
    ACFS_SRC_TEST = 2'b10,
    ACFS_SRC_RSV  = 2'b11
  } acfs_src_t;

  typedef enum logic [1:0] {
    ACFS_REF_POS  = 2'b00,
    ACFS_REF_NEG  = 2'b01,
    ACFS_REF_ZERO = 2'b10,
    ACFS_REF_OFF  = 2'b11
  } acfs_ref_t;

  typedef enum logic [1:0] {
    ACFS_CUR_0P1  = 2'b00,
    ACFS_CUR_0P33 = 2'b01,
    ACFS_CUR_1P0  = 2'b10,
    ACFS_CUR_OFF  = 2'b11
  } acfs_cur_t;

  // table entry: bits [3:0] channel-1, [5:4] source, [7:6] current, [8] reverse, [10:9] range
  localparam int unsigned ENT_W      = 11;
  localparam int unsigned ENT_CH_LSB = 0;
  localparam int unsigned ENT_SRC_LSB = 4;
  localparam int unsigned ENT_CUR_LSB = 6;
  localparam int unsigned ENT_REV_BIT = 8;
  localparam int unsigned ENT_RNG_LSB = 9;
endpackage

// ---- shared/acfs_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface acfs_if;
  logic        tbl_we;
  logic [6:0]  tbl_addr;
  logic [10:0] tbl_data;
  logic [7:0]  tbl_size_m1;
  logic [15:0] delay;
  logic        cal_cont;
  logic        acq_run;
  logic        smp_valid;
  logic        smp_temp;
  logic        smp_cal;
  logic [3:0]  smp_ch;
  logic [23:0] smp_code;

  modport device (
    input  tbl_we, tbl_addr, tbl_data, tbl_size_m1, delay, cal_cont, acq_run,
    output smp_valid, smp_temp, smp_cal, smp_ch, smp_code
  );
  modport host (
    output tbl_we, tbl_addr, tbl_data, tbl_size_m1, delay, cal_cont, acq_run,
    input  smp_valid, smp_temp, smp_cal, smp_ch, smp_code
  );
endinterface
`default_nettype wire

// ---- src/acfs_device.sv ----
//
// Summary of operation
// [R1] sixteen differential channels routable to amplifier
// [R2] channels 1-8 voltage or current output
// [R3] channels 9-16 voltage or voltage sense
// [R4] resistance pairs only k with k+8
// [R5] reference routed positive, negative or zero
// [R6] test current drive for line checks
// [R7] one-time calibration once at start
// [R8] host restarts after long run or heat
// [R9] continuous calibration uses delay slots per subrange
// [R10] raw codes out, no correction
// [R11] table length 1 to 128 entries
// [R12] host loads table before starting
// [R13] next entry each conversion, wrap to first
// [R14] delay slots after last entry
// [R15] each delay slot one start period
// [R16] delay count 0 to 65535
// [R17] host pairs opposite current entries
// [R18] repeated channel gets higher rate
// [R19] three current levels, only while polled
// [R20] temperature samples independent, about once per second
// [R21] one sample per entry, none in delay; the code also returns one cal-flagged sample per delay slot
`timescale 1ns/1ns
`default_nettype none
module acfs_device #(
  parameter int unsigned START_DIV = acfs_pkg::START_DIV_DEF,
  parameter int unsigned TEMP_DIV  = acfs_pkg::TEMP_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  acfs_if.device           bus,
  input  wire logic [23:0] adc_code_i,
  input  wire logic [15:0] temp_code_i,
  output logic [15:0]      sel_pos_o,
  output logic [15:0]      sel_neg_o,
  output logic [7:0]       cur_en_o,
  output logic [1:0]       cur_level_o,
  output logic             cur_rev_o,
  output logic [15:0]      test_cur_o,
  output logic [1:0]       reference_voltage_source_o,
  output logic [1:0]       cal_range_o,
  output logic             adc_start_o
);

  //////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] onehot(input logic [3:0] ch);
    onehot = 16'h0001 << ch;
  endfunction

  logic [10:0] tbl_r [acfs_pkg::TABLE_MAX];
  logic [31:0] div_r;
  logic        tick;
  logic [6:0]  idx_r;
  logic [15:0] dly_r;
  logic        run_r;
  logic        cal_once_r;
  logic        in_dly_r;
  logic [1:0]  sub_r;
  logic        pend_r;
  logic        pend_cal_r;
  logic [3:0]  pend_ch_r;
  logic [31:0] tdiv_r;
  logic        tpend_r;
  logic [10:0] ent;

  assign tick = (div_r == 32'(START_DIV - 1));
  assign ent  = tbl_r[idx_r];

  //////////////////////////////////////////////////////////////////////
  // table writes accepted only while stopped
  always_ff @(posedge clk_i)
  begin
    if (bus.tbl_we && !bus.acq_run)
      tbl_r[bus.tbl_addr] <= bus.tbl_data; // see [R11]
  end

  // one start pulse per converter period
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      div_r <= 32'h00000000;
    else if (tick)
      div_r <= 32'h00000000;
    else
      div_r <= div_r + 32'h00000001;
  end

  //////////////////////////////////////////////////////////////////////
  // sequencer: one step per period, a delay slot is a whole period
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      run_r      <= 1'b0;
      idx_r      <= 7'h00;
      dly_r      <= 16'h0000;
      in_dly_r   <= 1'b0;
      cal_once_r <= 1'b0;
      sub_r      <= 2'h0;
    end
    else if (!bus.acq_run)
    begin
      run_r    <= 1'b0;
      idx_r    <= 7'h00;
      in_dly_r <= 1'b0;
    end
    else if (tick)
    begin
      if (!run_r)
      begin
        run_r      <= 1'b1;
        cal_once_r <= !bus.cal_cont; // see [R7]
        idx_r      <= 7'h00;
      end
      else if (cal_once_r)
        cal_once_r <= 1'b0;
      else if (in_dly_r)
      begin
        if (dly_r == 16'h0001)
          in_dly_r <= 1'b0; // see [R15]
        dly_r <= dly_r - 16'h0001;
        if (bus.cal_cont)
          sub_r <= (sub_r == 2'(acfs_pkg::SUBRANGES - 1)) ? 2'h0 : sub_r + 2'h1; // see [R9]
      end
      else if (idx_r == bus.tbl_size_m1[6:0])
      begin
        idx_r <= 7'h00; // see [R13]
        if (bus.delay != 16'h0000)
        begin
          in_dly_r <= 1'b1; // see [R14]
          dly_r    <= bus.delay; // see [R16]
        end
      end
      else
        idx_r <= idx_r + 7'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // switch drive; current flows only on the polled pair
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      sel_pos_o   <= 16'h0000;
      sel_neg_o   <= 16'h0000;
      cur_en_o    <= 8'h00;
      cur_level_o <= 2'h3;
      cur_rev_o   <= 1'b0;
      test_cur_o  <= 16'h0000;
      reference_voltage_source_o <= 2'h3;
      cal_range_o <= 2'h0;
      adc_start_o <= 1'b0;
    end
    else
    begin
      adc_start_o <= tick && bus.acq_run;
      if (!bus.acq_run || (tick && (cal_once_r || in_dly_r)))
      begin
        sel_pos_o  <= 16'h0000;
        sel_neg_o  <= 16'h0000;
        cur_en_o   <= 8'h00; // see [R19]
        test_cur_o <= 16'h0000;
        // polarity steps pos, neg, zero with the subrange counter
        reference_voltage_source_o <= (bus.acq_run && (cal_once_r || bus.cal_cont)) ?
                                      sub_r : 2'h3; // see [R5]
        cal_range_o <= sub_r;
      end
      else if (tick)
      begin
        reference_voltage_source_o <= 2'h3;
        cur_level_o <= ent[7:6];
        cur_rev_o   <= ent[acfs_pkg::ENT_REV_BIT]; // see [R17]
        sel_pos_o   <= 16'h0000;
        sel_neg_o   <= 16'h0000;
        cur_en_o    <= 8'h00;
        test_cur_o  <= 16'h0000;
        case (acfs_pkg::acfs_src_t'(ent[5:4]))
          acfs_pkg::ACFS_SRC_RES:
          begin
            // pair k with k+8 only, sense on the upper member
            sel_pos_o <= onehot({1'b1, ent[2:0]}); // see [R4]
            sel_neg_o <= onehot({1'b1, ent[2:0]}); // see [R3]
            cur_en_o  <= 8'h01 << ent[2:0]; // see [R2]
          end
          acfs_pkg::ACFS_SRC_TEST:
          begin
            sel_pos_o  <= onehot(ent[3:0]);
            sel_neg_o  <= onehot(ent[3:0]);
            test_cur_o <= onehot(ent[3:0]); // see [R6]
          end
          default:
          begin
            sel_pos_o <= onehot(ent[3:0]); // see [R1]
            sel_neg_o <= onehot(ent[3:0]); // see [R18]
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // result of an entry returns one period later, raw
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pend_r     <= 1'b0;
      pend_cal_r <= 1'b0;
      pend_ch_r  <= 4'h0;
    end
    else if (!bus.acq_run)
      pend_r <= 1'b0;
    else if (tick)
    begin
      pend_r     <= run_r;
      pend_cal_r <= cal_once_r || in_dly_r;
      pend_ch_r  <= ent[3:0];
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      tdiv_r  <= 32'h00000000;
      tpend_r <= 1'b0;
    end
    else
    begin
      tdiv_r <= (tdiv_r == 32'(TEMP_DIV - 1)) ? 32'h00000000 : tdiv_r + 32'h00000001;
      if (tdiv_r == 32'(TEMP_DIV - 1))
        tpend_r <= 1'b1; // see [R20]
      else if (tpend_r && !(tick && pend_r))
        tpend_r <= 1'b0;
    end
  end

  // converter samples win the slot; temperature waits a cycle
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      bus.smp_valid <= 1'b0;
      bus.smp_temp  <= 1'b0;
      bus.smp_cal   <= 1'b0;
      bus.smp_ch    <= 4'h0;
      bus.smp_code  <= acfs_pkg::RST_CODE;
    end
    else if (tick && pend_r)
    begin
      bus.smp_valid <= 1'b1; // see [R21]
      bus.smp_temp  <= 1'b0;
      bus.smp_cal   <= pend_cal_r;
      bus.smp_ch    <= pend_ch_r;
      bus.smp_code  <= adc_code_i; // see [R10]
    end
    else if (tpend_r)
    begin
      bus.smp_valid <= 1'b1;
      bus.smp_temp  <= 1'b1;
      bus.smp_cal   <= 1'b0;
      bus.smp_ch    <= 4'h0;
      bus.smp_code  <= {acfs_pkg::TEMP_TAG[15:8], temp_code_i};
    end
    else
    begin
      bus.smp_valid <= 1'b0;
      bus.smp_temp  <= 1'b0;
      bus.smp_cal   <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ---- src/acfs_host.sv ----
`timescale 1ns/1ns
`default_nettype none
module acfs_host (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  acfs_if.host             bus,
  input  wire logic        wr_i,
  input  wire logic [6:0]  wr_addr_i,
  input  wire logic [10:0] wr_data_i,
  input  wire logic [7:0]  size_m1_i,
  input  wire logic [15:0] delay_i,
  input  wire logic        cal_cont_i,
  input  wire logic        start_i,
  input  wire logic        stop_i,
  output logic             busy_o,
  output logic             smp_valid_o,
  output logic             smp_temp_o,
  output logic             smp_cal_o,
  output logic [3:0]       smp_ch_o,
  output logic [23:0]      smp_code_o
);

  //////////////////////////////////////////////////////////////////////
  // table and size are only sent while stopped
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      bus.tbl_we      <= 1'b0;
      bus.tbl_addr    <= 7'h00;
      bus.tbl_data    <= 11'h000;
      bus.tbl_size_m1 <= 8'h00;
      bus.delay       <= 16'h0000;
      bus.cal_cont    <= 1'b0;
      bus.acq_run     <= 1'b0;
      busy_o          <= 1'b0;
    end
    else
    begin
      bus.tbl_we <= wr_i && !bus.acq_run; // see [R12]
      if (wr_i && !bus.acq_run)
      begin
        bus.tbl_addr <= wr_addr_i;
        bus.tbl_data <= wr_data_i;
      end
      if (stop_i)
      begin
        bus.acq_run <= 1'b0; // see [R8]
        busy_o      <= 1'b0;
      end
      else if (start_i && !bus.acq_run && !wr_i)
      begin
        bus.tbl_size_m1 <= {1'b0, size_m1_i[6:0]}; // see [R11]
        // continuous mode needs at least one delay slot
        bus.delay    <= (cal_cont_i && delay_i == 16'h0000) ? 16'h0001 : delay_i; // see [R9]
        bus.cal_cont <= cal_cont_i;
        bus.acq_run  <= 1'b1;
        busy_o       <= 1'b1;
      end
    end
  end

  // raw pass-through; averaging of reversed pairs is software's job
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      smp_valid_o <= 1'b0;
      smp_temp_o  <= 1'b0;
      smp_cal_o   <= 1'b0;
      smp_ch_o    <= 4'h0;
      smp_code_o  <= 24'h000000;
    end
    else
    begin
      smp_valid_o <= bus.smp_valid; // see [R17]
      smp_temp_o  <= bus.smp_temp;
      smp_cal_o   <= bus.smp_cal;
      smp_ch_o    <= bus.smp_ch;
      smp_code_o  <= bus.smp_code;
    end
  end

endmodule
`default_nettype wire

// ---- tb/acfs_checker.sv ----
`timescale 1ns/1ns
`default_nettype none
module acfs_checker #(
  parameter int unsigned START_DIV = 8
) (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        tbl_we,
  input  wire logic [7:0]  tbl_size_m1,
  input  wire logic [15:0] delay,
  input  wire logic        cal_cont,
  input  wire logic        acq_run,
  input  wire logic        smp_valid,
  input  wire logic        smp_temp,
  input  wire logic        smp_cal,
  input  wire logic [3:0]  smp_ch
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  logic        conv;
  logic        prev_r;
  logic [15:0] gap_r;
  assign conv = smp_valid && !smp_temp;
  ////////////////////////////////////////////////////////////
  // saturating gap count, so a long stop cannot wrap to a false match
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      gap_r <= 16'h0000;
    else if (conv)
      gap_r <= 16'h0001;
    else if (gap_r != 16'hFFFF)
      gap_r <= gap_r + 16'h0001;
  end
  // first gap after start is not periodic, so only later gaps count
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      prev_r <= 1'b0;
    else
      prev_r <= acq_run && (prev_r || conv);
  end
  ////////////////////////////////////////////////////////////
  a_gap_one_period: assert property (
    conv && prev_r |-> gap_r == 16'(START_DIV)) else $error("sample gap not one period");
  a_no_double_conv: assert property (
    conv |=> !conv) else $error("two converter samples back to back");
  a_stopped_quiet: assert property (
    !acq_run [*8] ##1 !acq_run [*8] |-> !conv) else $error("converter sample while stopped");
  a_write_when_idle: assert property (
    tbl_we |-> !acq_run) else $error("table written while running");
  a_size_in_range: assert property (
    acq_run |-> !tbl_size_m1[7]) else $error("table size above limit");
  a_cont_delay_min: assert property (
    acq_run && cal_cont |-> delay != 16'h0000) else $error("continuous cal without delay");
  a_temp_not_cal: assert property (
    smp_valid && smp_temp |-> !smp_cal) else $error("temperature sample flagged cal");
  a_run_holds_cfg: assert property (
    acq_run && $past(acq_run) |-> $stable({tbl_size_m1, delay, cal_cont}))
    else $error("configuration changed while running");
  c_cal_slot: cover property (conv && smp_cal);
  c_last_chan: cover property (conv && !smp_cal && smp_ch == 4'hF);
  c_temp: cover property (smp_valid && smp_temp);
  c_write: cover property (tbl_we);
endmodule
`default_nettype wire

// ---- tb/adc_channel_frame_sequencer_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module adc_channel_frame_sequencer_tb;
  localparam int unsigned SDIV = 8;
  logic        clk_i;
  logic        sys_rst_i;
  logic        wr_i;
  logic [6:0]  wr_addr_i;
  logic [10:0] wr_data_i;
  logic [7:0]  size_m1_i;
  logic [15:0] delay_i;
  logic        cal_cont_i;
  logic        start_i;
  logic        stop_i;
  logic        busy_o;
  logic        smp_valid_o;
  logic        smp_temp_o;
  logic        smp_cal_o;
  logic [3:0]  smp_ch_o;
  logic [23:0] smp_code_o;
  logic [23:0] adc_code_i;
  logic [15:0] temp_code_i;
  logic [7:0]  cur_en_o;
  logic [1:0]  cur_level_o;
  logic [1:0]  ref_src;
  logic [10:0] tbl [128];
  logic [4:0]  seen_q [$];
  logic [23:0] code_q [$];
  logic        cap;
  int          temps;
  int          fails;
  int          checks_done;
  int          cyc;
  int          seed;
  acfs_if bus_if ();
  acfs_host acfs_host_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus(bus_if), .wr_i(wr_i),
    .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i), .size_m1_i(size_m1_i), .delay_i(delay_i),
    .cal_cont_i(cal_cont_i), .start_i(start_i), .stop_i(stop_i), .busy_o(busy_o),
    .smp_valid_o(smp_valid_o), .smp_temp_o(smp_temp_o), .smp_cal_o(smp_cal_o),
    .smp_ch_o(smp_ch_o), .smp_code_o(smp_code_o));
  acfs_device #(.START_DIV(SDIV), .TEMP_DIV(1000)) acfs_device_i (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .bus(bus_if), .adc_code_i(adc_code_i), .temp_code_i(temp_code_i),
    .sel_pos_o(), .sel_neg_o(), .cur_en_o(cur_en_o), .cur_level_o(cur_level_o),
    .cur_rev_o(), .test_cur_o(), .reference_voltage_source_o(ref_src), .cal_range_o(),
    .adc_start_o());
  acfs_checker #(.START_DIV(SDIV)) acfs_checker_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .tbl_we(bus_if.tbl_we), .tbl_size_m1(bus_if.tbl_size_m1), .delay(bus_if.delay),
    .cal_cont(bus_if.cal_cont), .acq_run(bus_if.acq_run), .smp_valid(bus_if.smp_valid),
    .smp_temp(bus_if.smp_temp), .smp_cal(bus_if.smp_cal), .smp_ch(bus_if.smp_ch));
  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    if (fails == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask
  always @(posedge clk_i)
  begin
    if (cap && smp_valid_o && smp_temp_o)
      temps++;
    else if (cap && smp_valid_o)
    begin
      seen_q.push_back({smp_cal_o, smp_ch_o});
      code_q.push_back(smp_code_o);
    end
  end
  // hang guard, more than twice the planned run
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 25000)
    begin
      fails++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic run_case(input int n, input int d, input logic cont, input int cycles);
    int k;
    int p;
    int first;
    seen_q.delete();
    code_q.delete();
    temps = 0;
    tick();
    size_m1_i = 8'(n - 1);
    delay_i = 16'(d);
    cal_cont_i = cont;
    adc_code_i = 24'($random(seed));
    for (k = 0; k < n; k++)
    begin
      tbl[k] = 11'($random(seed)) & 11'h7DF;
      tbl[k][7:6] = 2'(k % 3);
      if (tbl[k][3])
        tbl[k][4] = 1'b0;
    end
    if (n == 1)
      tbl[0][3:0] = 4'hF;
    if (n == 4)
      tbl[2] = tbl[0];
    for (k = 0; k < n; k++)
    begin
      wr_i = 1'b1;
      wr_addr_i = 7'(k);
      wr_data_i = tbl[k];
      tick();
    end
    wr_i = 1'b0;
    tick();
    start_i = 1'b1;
    tick();
    start_i = 1'b0;
    cap = 1'b1;
    check("busy_run", 24'(busy_o), 24'h000001);
    repeat (cycles / 2) @(posedge clk_i);
    #1;
    // overwrite attempt mid-run must be dropped
    wr_i = 1'b1;
    wr_addr_i = 7'h00;
    wr_data_i = ~tbl[0];
    tick();
    wr_i = 1'b0;
    repeat (cycles / 2) @(posedge clk_i);
    #1;
    stop_i = 1'b1;
    tick();
    stop_i = 1'b0;
    cap = 1'b0;
    repeat (16) @(posedge clk_i);
    #1;
    check("busy_stop", 24'(busy_o), 24'h000000);
    check("cur_idle", 24'(cur_en_o), 24'h000000);
    check("ref_idle", 24'(ref_src), 24'h000003);
    first = 0;
    while (first < seen_q.size() && seen_q[first][4])
      first++;
    if (!cont)
      check("start_cal", 24'(first <= 1), 24'h000001);
    check("count", 24'(seen_q.size() >= cycles / SDIV - 4), 24'h000001);
    check("temp", 24'(temps >= 1 && temps <= cycles / 1000 + 2), 24'h000001);
    for (k = first; k < seen_q.size(); k++)
    begin
      p = (k - first) % (n + d);
      check("cal", 24'(seen_q[k][4]), 24'(p >= n));
      if (p < n)
        check("chan", 24'(seen_q[k][3:0]), 24'(tbl[p][3:0]));
      check("code", code_q[k], adc_code_i);
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  initial
  begin
    seed = 86791;
    fails = 0;
    checks_done = 0;
    cyc = 0;
    cap = 1'b0;
    sys_rst_i = 1'b1;
    wr_i = 1'b0;
    wr_addr_i = 7'h00;
    wr_data_i = 11'h000;
    size_m1_i = 8'h00;
    delay_i = 16'h0000;
    cal_cont_i = 1'b0;
    start_i = 1'b0;
    stop_i = 1'b0;
    adc_code_i = 24'h000000;
    temp_code_i = 16'($random(seed));
    repeat (3) @(posedge clk_i);
    #1;
    sys_rst_i = 1'b0;
    check("cur_level", 24'(cur_level_o), 24'h000003);
    check("ref_src", 24'(ref_src), 24'h000003);
    run_case(1, 0, 1'b0, 2500);
    run_case(4, 2, 1'b1, 3000);
    run_case(128, 1, 1'b1, 2600);
    run_case(5, 3, 1'b0, 2000);
    final_report();
  end
endmodule
`default_nettype wire
